// >>> pcpc_clock_ctrl.sv
`default_nettype none
module pcpc_clock_ctrl
   import pcpc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // pins
   input  wire pcpc_pix_t   pixel_port_in,
   input  wire logic        pixel_latch_in,
   input  wire logic        shift_clock_in,
   output logic             load_clock_out,
   output logic             programmable_clock_out,
   output logic             shift_clock_out,
   output logic [23:0]      pixel_stream,
   output logic             pixel_blank_n,
   output logic             pixel_sync_n,
   output pcpc_pll_t        pll_setting
);
   // --------------------
   // helpers
   // --------------------
   // load period in pixel clocks from the multiplex code
   function automatic logic [5:0] load_period(input logic [1:0] m);
      case (m)
         PCPC_MUX_8: load_period = 6'h08;
         PCPC_MUX_2: load_period = 6'h02;
         default:    load_period = 6'h04;
      endcase
   endfunction
   // known register index; the low four indices are contiguous
   function automatic logic idx_ok(input logic [5:0] i);
      idx_ok = (i <= PCPC_IDX_DIVS) || (i == PCPC_IDX_REF) ||
               (i == PCPC_IDX_PLLCTL) || (i == PCPC_IDX_FB);
   endfunction

   // --------------------
   // register storage
   // --------------------
   logic [7:0]  ctrl;        // mux rate, vsync cal, clock source, prg N
   logic [7:0]  mode;        // calibration arm and trigger
   logic [7:0]  pll_ctrl;    // ranges, post scale, fine step
   logic [6:0]  ref_reg;     // pll_reference_divider
   logic [6:0]  fb_reg;      // pll_feedback_divider
   logic        cal_valid;   // latch phase has been calibrated
   logic        cal_req;     // calibration waiting for a latch edge
   logic        late;        // last uncalibrated latch missed window
   logic        aw_hold;     // write address taken
   logic        w_hold;      // write data taken
   logic [5:0]  aw_idx;      // held write index
   logic        aw_bad;      // held write address out of range
   logic [7:0]  w_byte;      // held low data byte
   logic        w_en;        // held low byte strobe
   logic        do_write;    // both halves present

   // --------------------
   // axi4-lite write path
   // --------------------
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   assign do_write      = aw_hold && w_hold;

   // address and data are taken independently, in either order
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_idx  <= 6'h00;
         aw_bad  <= 1'b0;
         w_byte  <= 8'h00;
         w_en    <= 1'b0;
      end
      else if (do_write)
      begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold <= 1'b1;
            aw_idx  <= s_axi_awaddr[7:2];
            aw_bad  <= !idx_ok(s_axi_awaddr[7:2]);
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_en   <= s_axi_wstrb[0];
         end
      end
   end

   // response one cycle after both halves are held
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= aw_bad ? 2'h2 : 2'h0;  // slverr when unmapped
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // writable registers; status and divider words ignore writes
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ctrl     <= PCPC_RST_CTRL;
         mode     <= PCPC_RST_MODE;
         pll_ctrl <= PCPC_RST_PLLCTL;
         ref_reg  <= PCPC_RST_DIV;   // PLL starts halted
         fb_reg   <= PCPC_RST_DIV;
      end
      else if (do_write && w_en)
      begin
         case (aw_idx)
            PCPC_IDX_CTRL:   ctrl     <= w_byte;
            PCPC_IDX_MODE:   mode     <= w_byte;
            PCPC_IDX_PLLCTL: pll_ctrl <= w_byte;
            PCPC_IDX_REF:    ref_reg  <= w_byte[6:0];
            PCPC_IDX_FB:     fb_reg   <= w_byte[6:0];
            default:         ctrl     <= ctrl;
         endcase
      end
   end

   // --------------------
   // axi4-lite read path
   // --------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= idx_ok(s_axi_araddr[7:2]) ? 2'h0 : 2'h2;
         case (s_axi_araddr[7:2])
            PCPC_IDX_CTRL:   s_axi_rdata <= {24'h000000, ctrl};
            PCPC_IDX_MODE:   s_axi_rdata <= {24'h000000, mode};
            PCPC_IDX_STATUS: s_axi_rdata <= {28'h0000000, !pll_setting.run,
                                             late, cal_req, cal_valid};
            PCPC_IDX_DIVS:   s_axi_rdata <= {5'h00, pll_setting.fb_div,
                                             7'h00, pll_setting.ref_div};
            PCPC_IDX_REF:    s_axi_rdata <= {25'h0000000, ref_reg};
            PCPC_IDX_PLLCTL: s_axi_rdata <= {24'h000000, pll_ctrl};
            PCPC_IDX_FB:     s_axi_rdata <= {25'h0000000, fb_reg};
            default:         s_axi_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // --------------------
   // PLL divider setting
   // --------------------
   // analog loop, post scaler and clock mux sit outside this block
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pll_setting <= '0;
      end
      else
      begin
         pll_setting.run     <= (ref_reg != 7'h00) && (fb_reg != 7'h00);
         pll_setting.use_pll <= ctrl[PCPC_CTRL_INTCLK];
         pll_setting.ref_div <= ({2'h0, ref_reg} + PCPC_REF_OFFSET)
                                << pll_ctrl[PCPC_PCR_RANGE_REF];
         pll_setting.fb_div  <= ({2'h0, fb_reg, pll_ctrl[PCPC_PCR_FINE_LO +: 2]}
                                + PCPC_FB_OFFSET) << pll_ctrl[PCPC_PCR_RANGE_FB];
         pll_setting.post_sel <= pll_ctrl[PCPC_PCR_POST_LO +: 2];
      end
   end

   // --------------------
   // load and programmable clock generation
   // --------------------
   logic [4:0] cnt;       // free running pixel clock count
   logic [5:0] lper;      // load period
   logic [5:0] pper;      // programmable period, never below lper
   logic [4:0] lmask;     // phase mask inside one load period
   logic [4:0] phase;     // position inside the load period
   logic       next_load; // load clock value for the next cycle
   logic [4:0] next_pph;  // programmable phase for the next cycle

   assign lper  = load_period(ctrl[PCPC_CTRL_MUX_LOW +: 2]);
   assign lmask = lper[4:0] - 5'h01;
   assign phase = cnt & lmask;
   assign next_load = ((cnt + 5'h01) & lmask) < lper[5:1];
   assign next_pph  = (cnt + 5'h01) & (pper[4:0] - 5'h01);
   // an N below the load period would rise between load edges: clamp
   assign pper  = ((6'h04 << ctrl[PCPC_CTRL_PRG_LO +: 2]) < lper)
                ? lper : (6'h04 << ctrl[PCPC_CTRL_PRG_LO +: 2]);

   // both outputs come from flops so they carry no decode glitches
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         cnt                    <= 5'h00;
         load_clock_out         <= 1'b0;
         programmable_clock_out <= 1'b0;
      end
      else
      begin
         cnt            <= cnt + 5'h01;
         load_clock_out <= next_load;
         // rise only with the load clock, also right after a rate change
         programmable_clock_out <= programmable_clock_out
            ? (next_pph < pper[5:1]) : (next_pph == 5'h00 && next_load && !load_clock_out);
      end
   end

   // --------------------
   // pin synchronisers
   // --------------------
   logic      lat_s1, lat_s2, lat_s3;  // returned latch clock
   logic      sck_s1, sck_s2;          // shift clock input
   pcpc_pix_t pd_s1, pd_s2;            // pixel port, same delay as latch
   logic      lat_edge;                // rising edge of returned latch

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         {lat_s1, lat_s2, lat_s3} <= 3'h0;
         {sck_s1, sck_s2}         <= 2'h0;
         pd_s1                    <= '0;
         pd_s2                    <= '0;
      end
      else
      begin
         {lat_s1, lat_s2, lat_s3} <= {pixel_latch_in, lat_s1, lat_s2};
         {sck_s1, sck_s2}         <= {shift_clock_in, sck_s1};
         pd_s1                    <= pixel_port_in;
         pd_s2                    <= pd_s1;
      end
   end
   assign lat_edge = lat_s2 && !lat_s3;

   // --------------------
   // pixel latch, calibration and pipeline alignment
   // --------------------
   pcpc_pix_t  latched;     // word caught at the latch edge
   pcpc_pix_t  pipe;        // word moved into the pixel clock pipeline
   logic       pending;     // latched word not yet moved
   logic [1:0] bnd_left;    // load boundaries still to wait
   logic [4:0] cal_slot;    // calibrated transfer phase
   logic       xfer;        // move latched word this cycle
   logic       trig_d;      // previous trigger bit
   logic       sync_d;      // previous latched sync
   logic       cal_set;     // calibration request event
   logic [2:0] slot;        // serialiser position

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         latched <= '0;
      end
      else if (lat_edge)
      begin
         latched <= pd_s2;
      end
   end

   // arm then trigger starts one calibration; vsync repeats it
   assign cal_set = (mode[PCPC_MODE_TRIG] && !trig_d && mode[PCPC_MODE_ARM])
                 || (ctrl[PCPC_CTRL_VSCAL] && !mode[PCPC_MODE_TRIG]
                     && sync_d && !latched.sync_n);

   // a new request in the cycle a calibration completes is kept
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         trig_d    <= 1'b0;
         sync_d    <= 1'b1;
         cal_req   <= 1'b0;
         cal_valid <= 1'b0;
         cal_slot  <= 5'h00;
      end
      else
      begin
         trig_d  <= mode[PCPC_MODE_TRIG];
         sync_d  <= latched.sync_n;
         cal_req <= cal_set || (cal_req && !lat_edge);
         if (cal_req && lat_edge)
         begin
            cal_valid <= 1'b1;
            cal_slot  <= (phase + 5'h01) & lmask;
         end
      end
   end

   // calibrated: move at a fixed phase after the latch edge;
   // otherwise move at a load boundary, one later if the edge fell late
   assign xfer = pending && (cal_valid ? (phase == cal_slot)
                                       : (phase == 5'h00 && bnd_left == 2'h1));

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pending  <= 1'b0;
         bnd_left <= 2'h0;
         late     <= 1'b0;
      end
      else if (lat_edge)
      begin
         pending  <= 1'b1;
         late     <= !cal_valid && (phase >= lper[5:1]);
         bnd_left <= (!cal_valid && (phase >= lper[5:1])) ? 2'h2 : 2'h1;
      end
      else if (xfer)
      begin
         pending <= 1'b0;
      end
      else if (pending && phase == 5'h00 && bnd_left != 2'h1)
      begin
         bnd_left <= bnd_left - 2'h1;
      end
   end

   // serialiser: A,B,C,D at 4:1, A,B at 2:1, GA,RA..GD,RD at 8:1
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pipe          <= '0;
         slot          <= 3'h0;
         pixel_stream  <= 24'h000000;
         pixel_blank_n <= 1'b0;
         pixel_sync_n  <= 1'b1;
      end
      else
      begin
         if (xfer)
         begin
            pipe <= latched;
            slot <= 3'h0;
         end
         else
         begin
            slot <= slot + 3'h1;
         end
         if (ctrl[PCPC_CTRL_MUX_LOW +: 2] == PCPC_MUX_8)
         begin
            pixel_stream <= {16'h0000, slot[0]
                             ? pipe.colour[7'(slot[2:1]) * 7'h18 + 7'h10 +: 8]
                             : pipe.colour[7'(slot[2:1]) * 7'h18 + 7'h08 +: 8]};
         end
         else
         begin
            // seven bit offset: lane D starts at bit 72
            pixel_stream <= pipe.colour[7'(slot[1:0]) * 7'h18 +: 24];
         end
         pixel_blank_n <= pipe.blank_n;
         pixel_sync_n  <= pipe.sync_n;
      end
   end

   // --------------------
   // shift clock gating
   // --------------------
   // blanking covers retrace, so the video memory stops shifting there
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         shift_clock_out <= 1'b0;
      end
      else
      begin
         shift_clock_out <= sck_s2 && latched.blank_n;
      end
   end
endmodule
`default_nettype wire

// >>> pcpc_pkg.sv
// Overview of operation
// - load clock is pixel clock over 8/4/2
// - late latch phase only adds pipeline latency
// - arm then trigger bits start one calibration
// - vsync enable with trigger clear recalibrates
// - programmable clock is pixel clock over N, or over the load period when N is below it
// - programmable rising edges match load rising edges
// - shift clock out is shift in and not blank
// - shift clock stops during retrace blanking
// - source select bit picks internal PLL clock
// - zero reference or feedback divider halts PLL
// - reference divide 3-129 or 6-258 by two
// - feedback divide 12-519 or 24-1038 by two
// - post scaler divides by 1, 2, 4, 8
// - loop runs reference times feedback over reference
// - capture pixel port on latch input rising edge
`default_nettype none
package pcpc_pkg;
   // --------------------
   // register indices, byte address is four times the index
   // --------------------
   localparam logic [5:0] PCPC_IDX_CTRL   = 6'h00;
   localparam logic [5:0] PCPC_IDX_MODE   = 6'h01;
   localparam logic [5:0] PCPC_IDX_STATUS = 6'h02;
   localparam logic [5:0] PCPC_IDX_DIVS   = 6'h03;
   localparam logic [5:0] PCPC_IDX_REF    = 6'h0C;
   localparam logic [5:0] PCPC_IDX_PLLCTL = 6'h0D;
   localparam logic [5:0] PCPC_IDX_FB     = 6'h0F;
   // --------------------
   // field positions
   // --------------------
   localparam int PCPC_CTRL_MUX_LOW  = 0;  // mux_rate_bit_low
   localparam int PCPC_CTRL_MUX_HIGH = 1;  // mux_rate_bit_high
   localparam int PCPC_CTRL_VSCAL    = 2;  // vsync_calibration_enable
   localparam int PCPC_CTRL_INTCLK   = 3;  // internal_clock_source_select
   localparam int PCPC_CTRL_PRG_LO   = 4;  // programmable divider select
   localparam int PCPC_MODE_ARM      = 0;  // calibration_arm_bit
   localparam int PCPC_MODE_TRIG     = 1;  // calibration_trigger_bit
   localparam int PCPC_PCR_RANGE_REF = 1;  // reference_range_bit
   localparam int PCPC_PCR_RANGE_FB  = 2;  // feedback_range_bit
   localparam int PCPC_PCR_POST_LO   = 4;  // post_scale_bit_low
   localparam int PCPC_PCR_FINE_LO   = 6;  // fine_step_bit_low
   // --------------------
   // reset values and divider offsets
   // --------------------
   localparam logic [7:0] PCPC_RST_CTRL   = 8'h00;
   localparam logic [7:0] PCPC_RST_MODE   = 8'h00;
   localparam logic [7:0] PCPC_RST_PLLCTL = 8'h00;
   localparam logic [6:0] PCPC_RST_DIV    = 7'h00;
   localparam logic [8:0] PCPC_REF_OFFSET = 9'h002;
   localparam logic [10:0] PCPC_FB_OFFSET = 11'h008;
   // multiplex rate codes {high, low}
   localparam logic [1:0] PCPC_MUX_4 = 2'h0;
   localparam logic [1:0] PCPC_MUX_2 = 2'h1;
   localparam logic [1:0] PCPC_MUX_8 = 2'h2;
   // pixel port as captured from the frame buffer
   typedef struct packed
   {
      logic [95:0] colour;  // lanes A..D, 24 bits each {r,g,b}
      logic        sync_n;
      logic        blank_n;
      logic [7:0]  psel;
   } pcpc_pix_t;
   // divider setting handed to the analog loop
   typedef struct packed
   {
      logic        run;
      logic        use_pll;
      logic [8:0]  ref_div;
      logic [10:0] fb_div;
      logic [1:0]  post_sel;
   } pcpc_pll_t;
endpackage
`default_nettype wire

// >>> pcpc_clock_ctrl_asserts.sv
`default_nettype none
// --------------------
// port watcher for the clock control block
// --------------------
module pcpc_clock_ctrl_chk
   import pcpc_pkg::*;
(
   input wire logic      core_clk,
   input wire logic      rst_n,
   input wire logic      s_axi_awvalid,
   input wire logic      s_axi_awready,
   input wire logic      s_axi_wvalid,
   input wire logic      s_axi_wready,
   input wire logic      s_axi_bvalid,
   input wire logic      s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic      s_axi_arvalid,
   input wire logic      s_axi_arready,
   input wire logic      s_axi_rvalid,
   input wire logic      s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic      shift_clock_in,
   input wire logic      load_clock_out,
   input wire logic      programmable_clock_out,
   input wire logic      shift_clock_out,
   input wire pcpc_pll_t pll_setting
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // high half of a 2, 4 or 8 cycle period
   load_rate_a: assert property ($rose(load_clock_out) |-> ##[1:4] $fell(load_clock_out))
      else $error("load high phase wrong");
   prg_rate_a: assert property ($rose(programmable_clock_out) |->
      ##[2:16] !programmable_clock_out)
      else $error("divided high phase wrong");
   prg_sync_a: assert property ($rose(programmable_clock_out) |-> $rose(load_clock_out))
      else $error("divided rise off load rise");
   // two sync flops, then the output flop
   shift_gate_a: assert property (shift_clock_out |-> $past(shift_clock_in, 3))
      else $error("shift out without shift in");
   pll_halt_a: assert property (pll_setting.run |->
      pll_setting.ref_div >= 9'h003 && pll_setting.fb_div >= 11'h00C)
      else $error("loop runs below range");
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write response late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   write_c: cover property (s_axi_bvalid && s_axi_bready);
   read_c: cover property (s_axi_rvalid && s_axi_rready);
   prg_c: cover property ($rose(programmable_clock_out));
   shift_c: cover property (shift_clock_out);
endmodule
bind pcpc_clock_ctrl pcpc_clock_ctrl_chk i_pcpc_clock_ctrl_chk (.*);
`default_nettype wire

// >>> pcpc_fb_model.sv
`default_nettype none
// --------------------
// frame buffer: returns the load clock late, serves pixel words
// --------------------
module pcpc_fb_model
   import pcpc_pkg::*;
#(
   parameter int DLY = 3  // return delay in cycles, two or more
)(
   input wire logic        core_clk,
   input wire logic        load_clock_out,
   input wire logic        blank_n,
   input wire logic [23:0] pix,
   output var logic        pixel_latch_in,
   output var logic        shift_clock_in,
   output var pcpc_pix_t   port
);
   logic [DLY-1:0] dl = '0;  // delay line of the load clock
   initial port = '0;
   initial shift_clock_in = 1'b0;
   assign pixel_latch_in = dl[DLY-1];
   // load clock through shift clock wiring, back to the latch pin
   always @(posedge core_clk)
   begin
      dl <= {dl[DLY-2:0], load_clock_out};
      shift_clock_in <= load_clock_out;
      // change words on the latch fall so the rise sees them settled
      if (dl[DLY-1] && !dl[DLY-2])
         port <= '{colour: {4{pix}}, sync_n: 1'b1, blank_n: blank_n, psel: 8'h00};
   end
endmodule
`default_nettype wire

// >>> pixel_clock_pll_control_test.sv
`default_nettype none
module pixel_clock_pll_control_test
   import pcpc_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   // --------------------
   // stimulus and design nets
   // --------------------
   logic        core_clk = 1'b0, rst_n = 1'b0, blank = 1'b1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;  // only byte lane zero matters
   logic [23:0] pix = 24'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        pixel_latch_in, shift_clock_in, load_clock_out, programmable_clock_out;
   logic        shift_clock_out, pixel_blank_n, pixel_sync_n;
   logic [23:0] pixel_stream;
   pcpc_pix_t   pixel_port_in;
   pcpc_pll_t   pll_setting;
   logic [65:0] rq[$];  // read notes {mask, resp, data}
   logic [1:0]  bq[$];  // write response notes
   integer      seed = 32'h185f;
   int          num_errors = 0, check_count = 0;
   always #2 core_clk = ~core_clk;
   pcpc_fb_model #(.DLY(3)) i_pcpc_fb_model (
      .core_clk       (core_clk),
      .load_clock_out (load_clock_out),
      .blank_n        (blank),
      .pix            (pix),
      .pixel_latch_in (pixel_latch_in),
      .shift_clock_in (shift_clock_in),
      .port           (pixel_port_in)
   );
   pcpc_clock_ctrl i_pcpc_clock_ctrl (.*);
   // --------------------
   // shared tasks
   // --------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // write: both halves at once, each dropped when taken
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
      bq.push_back(er);
      @(posedge core_clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge core_clk);
      s_axi_bready <= 1'b0;
   endtask
   // read: ready raised once rvalid is seen
   task automatic rd(input logic [5:0] idx, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] er);
      rq.push_back({m, er, e});
      @(posedge core_clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge core_clk);
      s_axi_rready <= 1'b0;
   endtask
   // period of one of the two divided clocks, rise to rise
   task automatic per(input logic s, output int p);
      logic a;
      logic b = 1'b1;
      int   k = 0;
      p = 0;
      repeat (100)
      begin
         @(posedge core_clk);
         a = s ? programmable_clock_out : load_clock_out;
         if (a === 1'b1 && b === 1'b0) k++;
         if (k == 1) p++;
         b = a;
         if (k == 2) break;
      end
   endtask
   task summarize;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // answer watcher: oldest note against each completed response
   always @(posedge core_clk)
   begin
      logic [65:0] n;
      if (s_axi_rvalid && s_axi_rready)
      begin
         n = rq.pop_front();
         check({s_axi_rresp, s_axi_rdata & n[65:34]}, n[33:0]);
      end
      if (s_axi_bvalid && s_axi_bready)
         check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
   end
   // watchdog, well beyond the expected run
   initial
   begin
      #400000;
      num_errors++;
      summarize;
   end
   // --------------------
   // scenarios
   // --------------------
   initial
   begin
      logic [5:0]  ridx[5] = '{PCPC_IDX_CTRL, PCPC_IDX_MODE, PCPC_IDX_PLLCTL, PCPC_IDX_REF, PCPC_IDX_FB};
      int          lp[4] = '{4, 2, 8, 4};  // load period per mux code
      int          p;
      logic [6:0]  r, fv;
      logic [7:0]  pc;
      logic [8:0]  rdiv;
      logic [10:0] fdiv;
      logic        seen;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      // reset values, unmapped and read-only places
      for (int i = 0; i < 5; i++) rd(ridx[i], 32'h0, 32'hFF, 2'h0);
      rd(6'h04, 32'h0, 32'hFFFFFFFF, 2'h2);
      wr(6'h05, 8'h00, 2'h2);
      wr(PCPC_IDX_STATUS, 8'hFF, 2'h0);
      rd(PCPC_IDX_STATUS, 32'h0, 32'h7, 2'h0);
      $display("registers done");
      // every mux code against every divided clock choice
      for (int m = 0; m < 4; m++)
         for (int v = 0; v < 4; v++)
         begin
            wr(PCPC_IDX_CTRL, 8'((v << 4) | m), 2'h0);
            repeat (2) per(1'b0, p);  // skip the reprogrammed period
            check(34'(p), 34'(lp[m]));
            repeat (2) per(1'b1, p);
            check(34'(p), 34'((4 << v) > lp[m] ? (4 << v) : lp[m]));
         end
      check({33'h0, pll_setting.use_pll}, 34'h0);
      $display("clock rates done");
      // divider settings: zeros, range ends, then random values
      for (int i = 0; i < 8; i++)
      begin
         r = (i == 0) ? 7'h00 : (i == 2) ? 7'h01 : (i == 3) ? 7'h7F : 7'($random(seed));
         fv = (i == 1) ? 7'h00 : (i == 2) ? 7'h01 : (i == 3) ? 7'h7F : 7'($random(seed));
         pc = (i == 2) ? 8'h00 : (i == 3) ? 8'hC0 : 8'($random(seed)) & 8'hF6;
         wr(PCPC_IDX_REF, {1'b0, r}, 2'h0);
         wr(PCPC_IDX_FB, {1'b0, fv}, 2'h0);
         wr(PCPC_IDX_PLLCTL, pc, 2'h0);
         wr(PCPC_IDX_CTRL, 8'h08, 2'h0);
         rd(PCPC_IDX_REF, {25'h0, r}, 32'hFF, 2'h0);
         rdiv = (9'(r) + 9'h002) << pc[PCPC_PCR_RANGE_REF];
         fdiv = ((11'(fv) << 2) + 11'(pc[7:6]) + 11'h008) << pc[PCPC_PCR_RANGE_FB];
         if (r != 7'h00 && fv != 7'h00)
            check(34'(pll_setting), 34'({2'b11, rdiv, fdiv, pc[5:4]}));
         else
            check({33'h0, pll_setting.run}, 34'h0);
      end
      $display("dividers done");
      // one-time calibration: arm, then trigger
      wr(PCPC_IDX_MODE, 8'h01, 2'h0);
      wr(PCPC_IDX_MODE, 8'h03, 2'h0);
      repeat (40) @(posedge core_clk);
      rd(PCPC_IDX_STATUS, 32'h1, 32'h3, 2'h0);
      $display("calibration done");
      // shift clock held off while blanked, running otherwise
      for (int b = 0; b < 2; b++)
      begin
         blank <= 1'(b);
         repeat (30) @(posedge core_clk);
         seen = 1'b0;
         repeat (20) @(posedge core_clk) seen = seen | shift_clock_out;
         check({33'h0, seen}, 34'(b));
      end
      $display("shift gating done");
      // uniform lanes must come out unchanged
      pix <= 24'($random(seed));
      repeat (60) @(posedge core_clk);
      check({8'h00, pixel_stream, pixel_blank_n, pixel_sync_n}, {8'h00, pix, 2'b11});
      $display("pixel capture done");
      summarize;
   end
endmodule
`default_nettype wire
